/* design/lbk_ctrl.sv */
// Function
// - with bank n idle, bank m takes whatever its own state allows
// - beside open or closing bank, accept ACT, RD, WR, PRE; beside opening bank, RD, WR, PRE only
// - mode read accepted while a bank opens or closes
// - mode read goes to idle or active reading per target bank state
// - auto precharge does not change the inter-bank checks
// - after auto precharge, other banks take any valid command
// - mode read from resetting returns to resetting, not idle
// - reset by mode write from power-on, needs all banks idle
// - idle after precharge delay, active after activate delay
// - checks apply only with enable high twice and exit delay done
// - unlisted state and command pairs are refused
// - a write byte is stored when its mask is low, dropped when high
module lbk_ctrl (
   input  wire logic                        core_clk,    // channel clock
   input  wire logic                        reset_n,     // async reset
   input  wire logic                        cke,         // clock enable pin
   input  wire logic                        cmdValid,    // command present
   input  wire lbk_pkg::lbk_cmd_t           cmdCode,     // decoded command
   input  wire logic [lbk_pkg::BANK_W-1:0]  cmdBank,     // target bank
   input  wire logic                        cmdAllBanks, // precharge all
   input  wire logic                        cmdAutoPre,  // auto precharge
   input  wire logic                        wrBeatValid, // write beat present
   input  wire logic [lbk_pkg::DATA_W-1:0]  wrData,      // write beat data
   input  wire logic [lbk_pkg::MASK_W-1:0]  wrMask,      // byte mask, high drops
   output logic                             cmdAccept,   // command taken
   output logic                             cmdIllegal,  // command refused
   output logic [lbk_pkg::NBANK*6-1:0]      bankStates,  // bank states packed
   output lbk_pkg::lbk_dev_t                devState,    // device state
   output logic                             wrStore,     // beat stored
   output logic [lbk_pkg::DATA_W-1:0]       wrStoreData, // stored beat
   output logic [lbk_pkg::MASK_W-1:0]       wrByteEn     // bytes kept
);
   localparam int NB = lbk_pkg::NBANK;

   // ****************************************
   // declarations
   // ****************************************
   lbk_pkg::lbk_bank_t               bankSt [NB];
   lbk_pkg::lbk_bank_t               tgtSt;
   lbk_pkg::lbk_dev_t                dev_r;
   lbk_pkg::lbk_dev_t                devNxt;
   logic [NB-1:0]                    isIdle;
   logic [NB-1:0]                    isActive;
   logic [NB-1:0]                    isRead;
   logic [NB-1:0]                    isWrite;
   logic [NB-1:0]                    apPend;
   logic [NB-1:0]                    bankSel;
   logic [NB-1:0]                    preSel;
   logic [NB-1:0]                    preOk;
   logic [NB-1:0]                    goAct;
   logic [NB-1:0]                    goRd;
   logic [NB-1:0]                    goWr;
   logic [NB-1:0]                    goPre;
   logic                             ckePrev_r;
   logic                             ckeRise;
   logic                             exitBusy;
   logic                             rulesOn;
   logic                             cmdLive;
   logic                             legal;
   logic                             normLegal;
   logic                             allIdle;
   logic                             anyRead;
   logic                             anyWrite;
   logic                             noBurst;
   logic                             tgtCol;
   logic                             tgtOpen;
   logic                             actOk;
   logic                             rdOk;
   logic                             wrOk;
   logic                             preLegal;
   logic                             rrdBusy;
   logic                             initBusy;
   logic                             modeExpire;
   logic                             modeLoad;
   logic [lbk_pkg::CNT_W-1:0]        modeVal;
   logic                             wrStore_r;
   logic [lbk_pkg::DATA_W-1:0]       wrStoreData_r;
   logic [lbk_pkg::MASK_W-1:0]       wrByteEn_r;

   function automatic logic is_cmd(input lbk_pkg::lbk_cmd_t c,
                                   input lbk_pkg::lbk_cmd_t k);
      return c == k;
   endfunction

   function automatic logic acc(input lbk_pkg::lbk_cmd_t k);
      return cmdAccept && (cmdCode == k);
   endfunction

   // ****************************************
   // bank trackers
   // ****************************************
   for (genvar i = 0; i < NB; i++) begin : g_bank
      lbk_bank_fsm u_bank (
         .core_clk (core_clk),
         .reset_n  (reset_n),
         .goAct    (goAct[i]),
         .goRd     (goRd[i]),
         .goWr     (goWr[i]),
         .goPre    (goPre[i]),
         .autoPre  (cmdAutoPre),
         .state    (bankSt[i]),
         .apPend   (apPend[i])
      );
      assign isIdle[i]   = bankSt[i] == lbk_pkg::BK_IDLE;
      assign isActive[i] = bankSt[i] == lbk_pkg::BK_ACTIVE;
      assign isRead[i]   = bankSt[i] == lbk_pkg::BK_READ;
      assign isWrite[i]  = bankSt[i] == lbk_pkg::BK_WRITE;
      assign bankStates[i*6 +: 6] = bankSt[i];
   end

   // ****************************************
   // shared timers
   // ****************************************
   assign ckeRise = cke && !ckePrev_r;

   lbk_dly_cnt u_exit (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .load     (ckeRise),
      .loadVal  (lbk_pkg::EXIT_CYC),
      .busy     (exitBusy),
      .expire   ()
   );

   lbk_dly_cnt u_rrd (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .load     (acc(lbk_pkg::CMD_ACT)),
      .loadVal  (lbk_pkg::RRD_CYC),
      .busy     (rrdBusy),
      .expire   ()
   );

   lbk_dly_cnt u_init (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .load     (acc(lbk_pkg::CMD_MRWRST)),
      .loadVal  (lbk_pkg::INIT_CYC),
      .busy     (initBusy),
      .expire   ()
   );

   // one timer serves all mode states, they never overlap
   assign modeLoad = acc(lbk_pkg::CMD_MRR) || acc(lbk_pkg::CMD_MRW) ||
                     acc(lbk_pkg::CMD_REF);
   assign modeVal  = is_cmd(cmdCode, lbk_pkg::CMD_MRR) ? lbk_pkg::MRR_CYC :
                     is_cmd(cmdCode, lbk_pkg::CMD_MRW) ? lbk_pkg::MRW_CYC :
                                                         lbk_pkg::RFC_CYC;

   lbk_dly_cnt u_mode (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .load     (modeLoad),
      .loadVal  (modeVal),
      .busy     (),
      .expire   (modeExpire)
   );

   // ****************************************
   // command legality
   // ****************************************
   // first edge after reset release counts as an exit too
   assign rulesOn  = cke && ckePrev_r && !exitBusy;
   assign cmdLive  = cmdValid && (cmdCode != lbk_pkg::CMD_NOP);
   assign tgtSt    = bankSt[cmdBank];
   assign allIdle  = &isIdle;
   // burst state alone, auto precharge flag not consulted
   assign anyRead  = |isRead;
   assign anyWrite = |isWrite;
   assign noBurst  = !anyRead && !anyWrite;
   assign tgtCol   = (tgtSt == lbk_pkg::BK_ACTIVE ||
                      tgtSt == lbk_pkg::BK_READ ||
                      tgtSt == lbk_pkg::BK_WRITE) && !apPend[cmdBank];
   assign tgtOpen  = tgtSt == lbk_pkg::BK_ACTIVE ||
                     tgtSt == lbk_pkg::BK_OPEN;
   // other banks only matter through timing and burst direction
   assign actOk    = isIdle[cmdBank] && !rrdBusy;
   assign rdOk     = tgtCol && !anyWrite;
   assign wrOk     = tgtCol && !anyRead;
   assign preOk    = isIdle | isActive;
   assign preLegal = cmdAllBanks ? &preOk : preOk[cmdBank];

   always_comb begin
      case (cmdCode)
         lbk_pkg::CMD_ACT:    normLegal = actOk;
         lbk_pkg::CMD_RD:     normLegal = rdOk;
         lbk_pkg::CMD_WR:     normLegal = wrOk;
         lbk_pkg::CMD_PRE:    normLegal = preLegal;
         lbk_pkg::CMD_MRR:    normLegal = noBurst;
         lbk_pkg::CMD_MRW:    normLegal = allIdle;
         lbk_pkg::CMD_REF:    normLegal = allIdle;
         lbk_pkg::CMD_MRWRST: normLegal = allIdle;
         default:             normLegal = 1'b0;
      endcase
   end

   always_comb begin
      case (dev_r)
         lbk_pkg::DV_PWRON:
            legal = is_cmd(cmdCode, lbk_pkg::CMD_MRWRST);
         lbk_pkg::DV_RESET:
            legal = is_cmd(cmdCode, lbk_pkg::CMD_MRR) && initBusy;
         lbk_pkg::DV_NORM:
            legal = normLegal;
         default:
            legal = 1'b0;
      endcase
   end

   assign cmdAccept  = cmdLive && rulesOn && legal;
   assign cmdIllegal = cmdLive && !cmdAccept;

   // ****************************************
   // bank steering
   // ****************************************
   assign bankSel = {{(NB-1){1'b0}}, 1'b1} << cmdBank;
   assign preSel  = cmdAllBanks ? {NB{1'b1}} : bankSel;
   assign goAct   = {NB{acc(lbk_pkg::CMD_ACT)}} & bankSel;
   assign goRd    = {NB{acc(lbk_pkg::CMD_RD)}} & bankSel;
   assign goWr    = {NB{acc(lbk_pkg::CMD_WR)}} & bankSel;
   assign goPre   = {NB{acc(lbk_pkg::CMD_PRE)}} & preSel;

   // ****************************************
   // device state
   // ****************************************
   always_comb begin
      devNxt = dev_r;
      case (dev_r)
         lbk_pkg::DV_PWRON: begin
            if (acc(lbk_pkg::CMD_MRWRST)) begin
               devNxt = lbk_pkg::DV_RESET;
            end
         end
         lbk_pkg::DV_RESET: begin
            if (acc(lbk_pkg::CMD_MRR)) begin
               devNxt = lbk_pkg::DV_MRRR;
            end else if (!initBusy) begin
               devNxt = lbk_pkg::DV_NORM;
            end
         end
         lbk_pkg::DV_NORM: begin
            if (acc(lbk_pkg::CMD_MRR)) begin
               devNxt = tgtOpen ? lbk_pkg::DV_MRRA
                                : lbk_pkg::DV_MRRI;
            end else if (acc(lbk_pkg::CMD_MRW)) begin
               devNxt = lbk_pkg::DV_MRW;
            end else if (acc(lbk_pkg::CMD_REF)) begin
               devNxt = lbk_pkg::DV_REF;
            end else if (acc(lbk_pkg::CMD_MRWRST)) begin
               devNxt = lbk_pkg::DV_RESET;
            end
         end
         lbk_pkg::DV_MRRR: begin
            if (modeExpire) begin
               devNxt = lbk_pkg::DV_RESET;
            end
         end
         lbk_pkg::DV_MRRI, lbk_pkg::DV_MRRA,
         lbk_pkg::DV_MRW, lbk_pkg::DV_REF: begin
            if (modeExpire) begin
               devNxt = lbk_pkg::DV_NORM;
            end
         end
         default: begin
            devNxt = lbk_pkg::DV_PWRON;
         end
      endcase
   end

   assign devState = dev_r;

   // ****************************************
   // write mask path
   // ****************************************
   // mask travels with its own beat, so no realignment is needed
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         wrStore_r     <= 1'b0;
         wrStoreData_r <= '0;
         wrByteEn_r    <= '0;
      end else begin
         wrStore_r     <= wrBeatValid && anyWrite;
         wrStoreData_r <= wrData;
         wrByteEn_r    <= ~wrMask;
      end
   end

   assign wrStore     = wrStore_r;
   assign wrStoreData = wrStoreData_r;
   assign wrByteEn    = wrByteEn_r;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         dev_r     <= lbk_pkg::DV_PWRON;
         ckePrev_r <= 1'b0;
      end else begin
         dev_r     <= devNxt;
         ckePrev_r <= cke;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);

   sequence s_rst_mrr;
      cmdAccept && cmdCode == lbk_pkg::CMD_MRR &&
      dev_r == lbk_pkg::DV_RESET;
   endsequence

   sequence s_back_to_rst;
      (dev_r == lbk_pkg::DV_MRRR) [*4] ##1 dev_r == lbk_pkg::DV_RESET;
   endsequence

   a_rst_mrr_back: assert property (s_rst_mrr |=> s_back_to_rst)
      else $error("mode read in resetting did not return to resetting");
   a_cke_gate: assert property ((!cke || !$past(cke)) |-> !cmdAccept)
      else $error("command taken without two enable-high edges");
   a_mode_nop: assert property ((dev_r == lbk_pkg::DV_MRRI || dev_r == lbk_pkg::DV_MRW) && cmdLive |-> cmdIllegal)
      else $error("command taken during a mode state");
   a_rd_blocks_wr: assert property (anyRead && cmdCode == lbk_pkg::CMD_WR |-> !cmdAccept)
      else $error("write taken during read burst");
   a_wr_blocks_rd: assert property (anyWrite && cmdCode == lbk_pkg::CMD_RD |-> !cmdAccept)
      else $error("read taken during write burst");
   a_act_spacing: assert property (cmdAccept && cmdCode == lbk_pkg::CMD_ACT |=> !(cmdAccept && cmdCode == lbk_pkg::CMD_ACT))
      else $error("activates closer than row-to-row delay");
   a_mrw_all_idle: assert property (cmdAccept && cmdCode == lbk_pkg::CMD_MRW |-> allIdle ##1 (dev_r == lbk_pkg::DV_MRW) [*8] ##1 (dev_r == lbk_pkg::DV_MRW) [*2] ##1 dev_r == lbk_pkg::DV_NORM)
      else $error("mode write timing or idle check wrong");
   a_mrr_pick: assert property (s_rst_mrr or (cmdAccept && cmdCode == lbk_pkg::CMD_MRR && dev_r == lbk_pkg::DV_NORM && tgtSt == lbk_pkg::BK_ACTIVE) |=> dev_r == lbk_pkg::DV_MRRA || dev_r == lbk_pkg::DV_MRRR)
      else $error("mode read with open bank took wrong state");
   a_mask_store: assert property (wrBeatValid && anyWrite |=> wrStore && wrByteEn == ~$past(wrMask))
      else $error("write beat mask not applied");
   a_reset_entry: assert property (cmdAccept && cmdCode == lbk_pkg::CMD_MRWRST |-> allIdle ##1 dev_r == lbk_pkg::DV_RESET)
      else $error("reset command did not enter resetting");
endmodule

/* design/lbk_pkg.sv */
package lbk_pkg;
   // ****************************************
   // geometry and clock
   // ****************************************
   localparam int CLK_NS    = 50;
   localparam int NBANK     = 8;
   localparam int BANK_W    = 3;
   localparam int CNT_W     = 8;
   localparam int DATA_W    = 32;
   localparam int MASK_W    = 4;
   localparam int BURST_LEN = 8;

   // ****************************************
   // timing in its own unit
   // ****************************************
   localparam int T_RCD_NS   = 18;
   localparam int T_RP_NS    = 18;
   localparam int T_RRD_NS   = 10;
   localparam int T_RFCAB_NS = 130;
   localparam int T_XP_NS    = 8;
   localparam int T_XSR_NS   = 140;
   localparam int T_INIT5_NS = 10000;
   localparam int T_MRR_CK   = 4;
   localparam int T_MRW_CK   = 10;

   // least times round up, never below one cycle
   function automatic int min_cyc(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam logic [CNT_W-1:0] RCD_CYC   = CNT_W'(min_cyc(T_RCD_NS));
   localparam logic [CNT_W-1:0] RP_CYC    = CNT_W'(min_cyc(T_RP_NS));
   localparam logic [CNT_W-1:0] RRD_CYC   = CNT_W'(min_cyc(T_RRD_NS));
   localparam logic [CNT_W-1:0] RFC_CYC   = CNT_W'(min_cyc(T_RFCAB_NS));
   localparam logic [CNT_W-1:0] INIT_CYC  = CNT_W'(min_cyc(T_INIT5_NS));
   localparam logic [CNT_W-1:0] EXIT_CYC  =
      CNT_W'(min_cyc((T_XSR_NS > T_XP_NS) ? T_XSR_NS : T_XP_NS));
   localparam logic [CNT_W-1:0] MRR_CYC   = CNT_W'(T_MRR_CK);
   localparam logic [CNT_W-1:0] MRW_CYC   = CNT_W'(T_MRW_CK);
   localparam logic [CNT_W-1:0] BURST_CYC = CNT_W'(BURST_LEN / 2);

   // ****************************************
   // states and commands
   // ****************************************
   typedef enum logic [5:0] {
      BK_IDLE   = 6'h01,
      BK_OPEN   = 6'h02,
      BK_ACTIVE = 6'h04,
      BK_READ   = 6'h08,
      BK_WRITE  = 6'h10,
      BK_PRECH  = 6'h20
   } lbk_bank_t;

   typedef enum logic [7:0] {
      DV_PWRON = 8'h01,
      DV_RESET = 8'h02,
      DV_NORM  = 8'h04,
      DV_MRRI  = 8'h08,
      DV_MRRA  = 8'h10,
      DV_MRRR  = 8'h20,
      DV_MRW   = 8'h40,
      DV_REF   = 8'h80
   } lbk_dev_t;

   typedef enum logic [3:0] {
      CMD_NOP    = 4'h0,
      CMD_ACT    = 4'h1,
      CMD_RD     = 4'h2,
      CMD_WR     = 4'h3,
      CMD_PRE    = 4'h4,
      CMD_MRR    = 4'h5,
      CMD_MRW    = 4'h6,
      CMD_MRWRST = 4'h7,
      CMD_REF    = 4'h8
   } lbk_cmd_t;
endpackage

/* design/lbk_dly_cnt.sv */
module lbk_dly_cnt (
   input  wire logic                      core_clk, // channel clock
   input  wire logic                      reset_n,  // async reset
   input  wire logic                      load,     // start the delay
   input  wire logic [lbk_pkg::CNT_W-1:0] loadVal,  // delay in cycles
   output logic                           busy,     // delay running
   output logic                           expire    // last cycle of delay
);
   logic [lbk_pkg::CNT_W-1:0] count_r;
   logic [lbk_pkg::CNT_W-1:0] countNxt;

   assign countNxt = load ? loadVal :
                     (busy ? count_r - 1'b1 : count_r);
   assign busy     = count_r != '0;
   assign expire   = count_r == lbk_pkg::CNT_W'(1);

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         count_r <= '0;
      end else begin
         count_r <= countNxt;
      end
   end
endmodule

/* design/lbk_bank_fsm.sv */
module lbk_bank_fsm (
   input  wire logic          core_clk, // channel clock
   input  wire logic          reset_n,  // async reset
   input  wire logic          goAct,    // accepted activate
   input  wire logic          goRd,     // accepted read
   input  wire logic          goWr,     // accepted write
   input  wire logic          goPre,    // accepted precharge
   input  wire logic          autoPre,  // column command closes row
   output lbk_pkg::lbk_bank_t state,    // bank state
   output logic               apPend    // auto precharge armed
);
   localparam int RCD_D = lbk_pkg::RCD_CYC;

   lbk_pkg::lbk_bank_t        state_r;
   lbk_pkg::lbk_bank_t        stateNxt;
   logic [lbk_pkg::CNT_W-1:0] cnt_r;
   logic [lbk_pkg::CNT_W-1:0] cntNxt;
   logic                      ap_r;
   logic                      apNxt;
   logic                      lastCyc;

   assign lastCyc = cnt_r == lbk_pkg::CNT_W'(1);
   assign state   = state_r;
   assign apPend  = ap_r;

   // ****************************************
   // next state
   // ****************************************
   // legality is settled upstream, so any go is taken as given
   always_comb begin
      stateNxt = state_r;
      cntNxt   = (cnt_r == '0) ? cnt_r : cnt_r - 1'b1;
      apNxt    = ap_r;
      if (goAct) begin
         stateNxt = lbk_pkg::BK_OPEN;
         cntNxt   = lbk_pkg::RCD_CYC;
      end else if (goRd || goWr) begin
         stateNxt = goRd ? lbk_pkg::BK_READ : lbk_pkg::BK_WRITE;
         cntNxt   = lbk_pkg::BURST_CYC;
         apNxt    = autoPre;
      end else if (goPre) begin
         stateNxt = lbk_pkg::BK_PRECH;
         cntNxt   = lbk_pkg::RP_CYC;
      end else begin
         case (state_r)
            lbk_pkg::BK_OPEN: begin
               if (lastCyc) begin
                  stateNxt = lbk_pkg::BK_ACTIVE;
               end
            end
            lbk_pkg::BK_READ, lbk_pkg::BK_WRITE: begin
               if (lastCyc) begin
                  stateNxt = ap_r ? lbk_pkg::BK_PRECH
                                  : lbk_pkg::BK_ACTIVE;
                  cntNxt   = ap_r ? lbk_pkg::RP_CYC : '0;
                  apNxt    = 1'b0;
               end
            end
            lbk_pkg::BK_PRECH: begin
               if (lastCyc) begin
                  stateNxt = lbk_pkg::BK_IDLE;
               end
            end
            lbk_pkg::BK_IDLE, lbk_pkg::BK_ACTIVE: begin
               stateNxt = state_r;
            end
            default: begin
               stateNxt = lbk_pkg::BK_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= lbk_pkg::BK_IDLE;
         cnt_r   <= '0;
         ap_r    <= 1'b0;
      end else begin
         state_r <= stateNxt;
         cnt_r   <= cntNxt;
         ap_r    <= apNxt;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   a_act_opens: assert property (@(posedge core_clk) disable iff (!reset_n)
      goAct |=> state_r == lbk_pkg::BK_OPEN ##RCD_D
      state_r == lbk_pkg::BK_ACTIVE)
      else $error("bank did not open after activate delay");
   a_ap_closes: assert property (@(posedge core_clk) disable iff (!reset_n)
      (state_r == lbk_pkg::BK_READ && ap_r && lastCyc && !goRd && !goWr)
      |=> state_r == lbk_pkg::BK_PRECH)
      else $error("auto precharge did not follow read burst");
endmodule

/* sim/lbk_wr_model.sv */
module lbk_wr_model (
   input  wire logic        core_clk,    // channel clock
   input  wire logic        reset_n,     // async reset
   input  wire logic        beatGo,      // send one beat next cycle
   input  wire logic [31:0] beatData,    // data of that beat
   input  wire logic [3:0]  beatMask,    // mask of that beat
   output logic             wrBeatValid, // beat on the bus
   output logic [31:0]      wrData,      // beat data
   output logic [3:0]       wrMask       // byte mask, high drops
);
   timeunit 1ns;
   timeprecision 1ps;
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         wrBeatValid <= 1'h0;
         wrData      <= 32'h0;
         wrMask      <= 4'h0;
      end else begin
         wrBeatValid <= beatGo;
         // released lines toggle so stale data never passes for a beat
         wrData      <= beatGo ? beatData : ~wrData;
         wrMask      <= beatGo ? beatMask : ~wrMask;
      end
   end
endmodule

/* sim/tb_top.sv */
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam lbk_pkg::lbk_cmd_t ACT = lbk_pkg::CMD_ACT;
   localparam lbk_pkg::lbk_cmd_t RD  = lbk_pkg::CMD_RD;
   localparam lbk_pkg::lbk_cmd_t WR  = lbk_pkg::CMD_WR;
   localparam lbk_pkg::lbk_cmd_t PRE = lbk_pkg::CMD_PRE;
   localparam lbk_pkg::lbk_cmd_t MRR = lbk_pkg::CMD_MRR;
   localparam lbk_pkg::lbk_cmd_t MRW = lbk_pkg::CMD_MRW;
   logic        core_clk, reset_n, cke, cmdValid, cmdAllBanks, cmdAutoPre;
   logic        beatGo, wrBeatValid, cmdAccept, cmdIllegal, wrStore;
   logic [2:0]  cmdBank;
   logic [3:0]  wrMask, wrByteEn;
   logic [31:0] wrData, wrStoreData;
   logic [47:0] bankStates;
   lbk_pkg::lbk_cmd_t cmdCode;
   lbk_pkg::lbk_dev_t devState;
   int          error_cnt, num_checks, cycles;
   lbk_ctrl lbk_ctrl_inst (.core_clk(core_clk), .reset_n(reset_n),
      .cke(cke), .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdBank(cmdBank),
      .cmdAllBanks(cmdAllBanks), .cmdAutoPre(cmdAutoPre),
      .wrBeatValid(wrBeatValid), .wrData(wrData), .wrMask(wrMask),
      .cmdAccept(cmdAccept), .cmdIllegal(cmdIllegal),
      .bankStates(bankStates), .devState(devState), .wrStore(wrStore),
      .wrStoreData(wrStoreData), .wrByteEn(wrByteEn));
   lbk_wr_model lbk_wr_model_inst (.core_clk(core_clk), .reset_n(reset_n),
      .beatGo(beatGo), .beatData(32'hC0DE5A17), .beatMask(4'h2),
      .wrBeatValid(wrBeatValid), .wrData(wrData), .wrMask(wrMask));
   task automatic give_verdict();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input logic [47:0] g, input logic [47:0] e);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected at %0t: got %h exp %h", $time, g, e);
      end
   endtask
   // x packs auto precharge, all banks and write beat request
   task automatic iss(input lbk_pkg::lbk_cmd_t c, input int b,
                      input logic ok, input logic [2:0] x = 3'h0);
      @(posedge core_clk);
      cmdValid    <= 1'h1;
      cmdCode     <= c;
      cmdBank     <= 3'(b);
      {cmdAutoPre, cmdAllBanks, beatGo} <= x;
      #10;
      chk({cmdAccept, cmdIllegal}, {ok, !ok});
   endtask
   task automatic idle(input int n);
      @(posedge core_clk);
      cmdValid <= 1'h0;
      beatGo   <= 1'h0;
      repeat (n - 1) @(posedge core_clk);
      #10;
   endtask
   task automatic t_start();
      iss(lbk_pkg::CMD_MRWRST, 0, 1'h0);
      idle(6);
      iss(ACT, 0, 1'h0);
      iss(lbk_pkg::CMD_MRWRST, 0, 1'h1);
      iss(MRR, 0, 1'h1);
      idle(1);
      chk(devState, lbk_pkg::DV_MRRR);
      idle(4);
      chk(devState, lbk_pkg::DV_RESET);
      idle(200);
      chk(devState, lbk_pkg::DV_NORM);
   endtask
   task automatic t_banks();
      iss(ACT, 0, 1'h1);
      iss(ACT, 1, 1'h0);
      iss(ACT, 1, 1'h1);
      chk(bankStates[5:0], lbk_pkg::BK_ACTIVE);
      iss(RD, 0, 1'h1);
      iss(WR, 1, 1'h0);
      iss(MRR, 1, 1'h0);
      idle(2);
      iss(WR, 1, 1'h1, 3'h5);
      iss(RD, 0, 1'h0);
      iss(PRE, 0, 1'h1);
      chk({wrStore, wrByteEn, wrStoreData}, {1'h1, 4'hD, 32'hC0DE5A17});
      idle(5);
      chk(bankStates[11:0], 12'h041);
   endtask
   task automatic t_mode();
      iss(ACT, 4, 1'h1);
      iss(PRE, 0, 1'h0, 3'h2);
      iss(PRE, 0, 1'h1, 3'h2);
      idle(2);
      chk(bankStates, {8{6'h01}});
      iss(lbk_pkg::CMD_REF, 0, 1'h1);
      iss(ACT, 0, 1'h0);
      idle(3);
      iss(MRW, 0, 1'h1);
      iss(RD, 0, 1'h0);
      idle(9);
      chk(devState, lbk_pkg::DV_MRW);
      idle(1);
      chk(devState, lbk_pkg::DV_NORM);
      iss(ACT, 5, 1'h1);
      iss(MRR, 5, 1'h1);
      idle(1);
      chk(devState, lbk_pkg::DV_MRRA);
      idle(5);
      iss(MRW, 0, 1'h0);
      iss(MRR, 0, 1'h1);
      idle(1);
      chk(devState, lbk_pkg::DV_MRRI);
      idle(5);
      @(posedge core_clk);
      cke <= 1'h0;
      iss(ACT, 6, 1'h0);
      @(posedge core_clk);
      cke <= 1'h1;
      iss(ACT, 6, 1'h0);
      idle(5);
      iss(ACT, 6, 1'h1);
   endtask
   initial begin
      core_clk = 1'h0;
      forever #25 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 1000) begin
         error_cnt++;
         give_verdict();
      end
   end
   initial begin
      {reset_n, cmdValid, cmdAllBanks, cmdAutoPre, beatGo} = 5'h0;
      {cke, cmdBank, error_cnt, num_checks, cycles} = '0;
      cke = 1'h1;
      cmdCode = lbk_pkg::CMD_NOP;
      repeat (6) @(posedge core_clk);
      reset_n <= 1'h1;
      t_start();
      t_banks();
      t_mode();
      give_verdict();
   end
endmodule
